// *** hw/cmt_defs.svh ***
// offsets, field positions, reset values and timing figures of the charger register bank
`ifndef CMT_DEFS_SVH
`define CMT_DEFS_SVH

// ------------------------------------------------------------
// register offsets and reset values
// ------------------------------------------------------------
`define CMT_ADDR_INPUT_CURRENT_LIMIT_UVLO   8'h09
`define CMT_ADDR_MONITOR     8'h0A
`define CMT_ADDR_DPM_TIMER   8'h0B
`define CMT_RST_INPUT_CURRENT_LIMIT_UVLO    8'h02
`define CMT_RST_DPM_TIMER    8'h4A
`define CMT_RST_LIMIT_MA     10'h000
`define CMT_RST_FLOOR_MV     13'h11F8
`define CMT_READ_UNMAPPED    8'h00

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define CMT_BIT_SOFT_RESET   7
`define CMT_INPUT_CURRENT_LIMIT_MSB         5
`define CMT_INPUT_CURRENT_LIMIT_LSB         3
`define CMT_UVLO_MSB         2
`define CMT_UVLO_LSB         0
`define CMT_BIT_TRIGGER      7
`define CMT_BIT_DPM_DISABLE  7
`define CMT_FLOOR_MSB        6
`define CMT_FLOOR_LSB        4
`define CMT_BIT_HALF_SPEED   3
`define CMT_TMR_MSB          2
`define CMT_TMR_LSB          1

// ------------------------------------------------------------
// field encodings and weights
// ------------------------------------------------------------
`define CMT_UVLO_RSVD_MAX    3'h1
`define CMT_BAND_TOP         2'h3
`define CMT_BAND_BOTTOM      2'h0
`define CMT_STEP_NONE        3'h0
`define CMT_INPUT_CURRENT_LIMIT_W2_MA       10'h0C8
`define CMT_INPUT_CURRENT_LIMIT_W1_MA       10'h064
`define CMT_INPUT_CURRENT_LIMIT_W0_MA       10'h032
`define CMT_FLOOR_BASE_MV    13'h1068
`define CMT_FLOOR_STEP_MV    13'h0064
`define CMT_TMR_30MIN        2'h0
`define CMT_TMR_3H           2'h1
`define CMT_TMR_9H           2'h2
`define CMT_TMR_OFF          2'h3

// ------------------------------------------------------------
// times
// ------------------------------------------------------------
`define CMT_CLK_PERIOD_NS    4
`define CMT_TICK_PERIOD_NS   1000000000
`define CMT_SETTLE_NS        2000
`define CMT_LIMIT_A_MIN      30
`define CMT_LIMIT_B_HOUR     3
`define CMT_LIMIT_C_HOUR     9
`define CMT_SEC_PER_MIN      60
`define CMT_SEC_PER_HOUR     3600

`endif

// *** hw/cmt_pkg.sv ***
// types shared by the charger register bank and its safety timer
package cmt_pkg;

  typedef logic [1:0] cmt_band_type;
  typedef logic [2:0] cmt_step_type;

  typedef enum logic [1:0] {
    MON_IDLE,
    MON_SETTLE,
    MON_EVAL
  } cmt_mon_state_type;

  typedef struct packed {
    logic [7:0]        input_current_limit_uvlo;
    logic [7:0]        dpm_timer;
    cmt_band_type      band;
    cmt_step_type      step;
    cmt_mon_state_type mon_state;
    cmt_band_type      band_sel;
    logic [15:0]       settle_cnt;
    cmt_step_type      step_s1;
    cmt_step_type      step_s2;
    cmt_step_type      step_s3;
    cmt_step_type      step_filt;
    logic [7:0]        rdata;
    logic              rvalid;
    logic              done;
    logic [9:0]        input_current_limit_ma;
    logic [12:0]       floor_mv;
  } cmt_core_state_type;

  typedef struct packed {
    logic [31:0] prescale;
    logic        half_phase;
    logic [15:0] secs;
    logic        expired;
  } cmt_timer_state_type;

endpackage

// *** hw/cmt_safety_timer.sv ***
// charge safety timer with optional half-rate outside the constant current and voltage phases
`timescale 1ns/10ps
`include "cmt_defs.svh"

module cmt_safety_timer #(
  parameter int unsigned TICK_CYCLES = `CMT_TICK_PERIOD_NS / `CMT_CLK_PERIOD_NS
) (
  input  wire logic       core_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       charging_active_i,
  input  wire logic       constant_current_phase_i,
  input  wire logic       constant_voltage_phase_i,
  input  wire logic       timer_half_speed_enable_i,
  input  wire logic [1:0] safety_timer_select_i,
  output logic            safety_timer_expired_o
);
  import cmt_pkg::*;

  localparam logic [15:0] LIMIT_A = 16'(`CMT_LIMIT_A_MIN * `CMT_SEC_PER_MIN);
  localparam logic [15:0] LIMIT_B = 16'(`CMT_LIMIT_B_HOUR * `CMT_SEC_PER_HOUR);
  localparam logic [15:0] LIMIT_C = 16'(`CMT_LIMIT_C_HOUR * `CMT_SEC_PER_HOUR);
  localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);

  if (TICK_CYCLES < 2) begin : g_bad_tick
    $error("TICK_CYCLES must be at least 2");
  end

  cmt_timer_state_type s_reg;
  cmt_timer_state_type s_next;
  logic                tick;
  logic                slow;
  logic [15:0]         limit;

  // ------------------------------------------------------------
  // one-second tick, rate select and limit decode
  // ------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    tick   = (s_reg.prescale == TICK_LAST);
    slow   = timer_half_speed_enable_i && !constant_current_phase_i && !constant_voltage_phase_i;
    unique case (safety_timer_select_i)
      `CMT_TMR_30MIN: limit = LIMIT_A;
      `CMT_TMR_3H:    limit = LIMIT_B;
      `CMT_TMR_9H:    limit = LIMIT_C;
      `CMT_TMR_OFF:   limit = 16'hFFFF;
    endcase
    // no charge or timers disabled: hold everything cleared
    if (!charging_active_i || safety_timer_select_i == `CMT_TMR_OFF) begin
      s_next = '0;
    end else begin
      s_next.prescale = tick ? 32'h0000_0000 : s_reg.prescale + 32'h0000_0001;
      // half rate: only every second tick counts, so the limit takes twice as long
      if (tick && !s_reg.expired) begin
        s_next.half_phase = slow ? !s_reg.half_phase : 1'b0;
        if (!slow || s_reg.half_phase) begin
          s_next.secs = s_reg.secs + 16'h0001;
        end
      end
      if (s_reg.secs >= limit) begin
        s_next.expired = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign safety_timer_expired_o = s_reg.expired;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  chk_timer_off_clear: assert property (
    safety_timer_select_i == `CMT_TMR_OFF |=> !safety_timer_expired_o && s_reg.secs == 16'h0000)
    else $error("disabled safety timer still counting");
  chk_half_rate_skip: assert property (
    charging_active_i && safety_timer_select_i != `CMT_TMR_OFF && tick && slow && !s_reg.half_phase
    |=> s_reg.secs == $past(s_reg.secs))
    else $error("slowed timer advanced on the skipped tick");
  chk_full_rate_step: assert property (
    charging_active_i && safety_timer_select_i != `CMT_TMR_OFF && tick && !slow && !s_reg.expired
    |=> s_reg.secs == $past(s_reg.secs) + 16'h0001)
    else $error("full rate timer missed a tick");
endmodule

// *** hw/cmt_charger_monitor_timer_regs.sv ***
// byte register bank: input limit and lockout, battery voltage monitor, input floor and safety timer
// Contract
// - writing one to soft-reset bit restores defaults
// - input limit bits weigh 200, 100, 50 mA
// - writing trigger bit starts a measurement; reads zero
// - coarse band codes 11..00 span 100..60 percent
// - fine step codes report 8,6,4,2,0 percent
// - search from top band down until non-zero step
// - no step found gives result 00 000
// - monitor bits one and zero read zero
// - half-speed bit slows timer outside CC/CV
// - timer select 30 min, 3 h, 9 h, off
// - lowest bit of floor register resets zero
// - defaults apply until host rewrites them
`timescale 1ns/10ps
`include "cmt_defs.svh"

module cmt_charger_monitor_timer_regs #(
  parameter int unsigned TICK_CYCLES   = `CMT_TICK_PERIOD_NS / `CMT_CLK_PERIOD_NS,
  parameter int unsigned SETTLE_CYCLES = (`CMT_SETTLE_NS + `CMT_CLK_PERIOD_NS - 1) / `CMT_CLK_PERIOD_NS
) (
  input  wire logic                 core_clk_i,
  input  wire logic                 rst_n_i,
  input  wire logic                 reg_wr_i,
  input  wire logic                 reg_rd_i,
  input  wire logic [7:0]           reg_addr_i,
  input  wire logic [7:0]           reg_wdata_i,
  output logic      [7:0]           reg_rdata_o,
  output logic                      reg_rvalid_o,
  input  wire cmt_pkg::cmt_step_type monitor_step_i,
  input  wire logic                 low_power_request_i,
  output cmt_pkg::cmt_band_type     monitor_band_select_o,
  output logic                      monitor_busy_o,
  output logic                      monitor_done_o,
  output cmt_pkg::cmt_band_type     monitor_coarse_band_o,
  output cmt_pkg::cmt_step_type     monitor_fine_step_o,
  input  wire logic                 charging_active_i,
  input  wire logic                 constant_current_phase_i,
  input  wire logic                 constant_voltage_phase_i,
  output logic                      safety_timer_expired_o,
  output logic      [2:0]           input_current_limit_o,
  output logic      [9:0]           input_current_limit_ma_o,
  output logic      [2:0]           battery_undervoltage_lockout_o,
  output logic                      input_dpm_disable_o,
  output logic      [2:0]           input_voltage_floor_o,
  output logic      [12:0]          input_voltage_floor_mv_o,
  output logic                      timer_half_speed_enable_o,
  output logic      [1:0]           safety_timer_select_o
);
  import cmt_pkg::*;

  localparam logic [15:0] SETTLE_LAST = 16'(SETTLE_CYCLES - 1);

  // the step input needs three stages plus agreement before a band is judged
  if (SETTLE_CYCLES < 5 || SETTLE_CYCLES > 65536) begin : g_bad_settle
    $error("SETTLE_CYCLES must lie between 5 and 65536");
  end

  // defaults that the bank holds until the host rewrites them
  localparam cmt_core_state_type CORE_RESET = '{
    input_current_limit_uvlo:  `CMT_RST_INPUT_CURRENT_LIMIT_UVLO,
    dpm_timer:  `CMT_RST_DPM_TIMER,
    band:       `CMT_BAND_BOTTOM,
    step:       `CMT_STEP_NONE,
    mon_state:  MON_IDLE,
    band_sel:   `CMT_BAND_BOTTOM,
    settle_cnt: 16'h0000,
    step_s1:    `CMT_STEP_NONE,
    step_s2:    `CMT_STEP_NONE,
    step_s3:    `CMT_STEP_NONE,
    step_filt:  `CMT_STEP_NONE,
    rdata:      8'h00,
    rvalid:     1'b0,
    done:       1'b0,
    input_current_limit_ma:    `CMT_RST_LIMIT_MA, // limit code 000 at reset decodes to no current
    floor_mv:   `CMT_RST_FLOOR_MV
  };

  // ------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------
  logic [1:0] rst_pipe;
  logic       rst_n;

  // assert asynchronously, release two edges later so no flop sees a partial release
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_pipe <= 2'b00;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[1];

  // ------------------------------------------------------------
  // state and next state
  // ------------------------------------------------------------
  cmt_core_state_type s_reg;
  cmt_core_state_type s_next;
  logic               wr_input_current_limit;
  logic               wr_mon;
  logic               wr_dpm;
  logic               soft_reset;
  logic               start;

  always_comb begin
    wr_input_current_limit    = reg_wr_i && reg_addr_i == `CMT_ADDR_INPUT_CURRENT_LIMIT_UVLO;
    wr_mon     = reg_wr_i && reg_addr_i == `CMT_ADDR_MONITOR;
    wr_dpm     = reg_wr_i && reg_addr_i == `CMT_ADDR_DPM_TIMER;
    soft_reset = wr_input_current_limit && reg_wdata_i[`CMT_BIT_SOFT_RESET];
    start      = (wr_mon && reg_wdata_i[`CMT_BIT_TRIGGER]) || low_power_request_i;
  end

  always_comb begin
    s_next        = s_reg;
    s_next.rvalid = 1'b0;
    s_next.done   = 1'b0;

    // step comparator is analog and asynchronous: three stages, accept once two and three agree
    s_next.step_s1 = monitor_step_i;
    s_next.step_s2 = s_reg.step_s1;
    s_next.step_s3 = s_reg.step_s2;
    if (s_reg.step_s2 == s_reg.step_s3) begin
      s_next.step_filt = s_reg.step_s3;
    end

    // read answer one edge after the strobe; unmapped offsets answer zero
    if (reg_rd_i) begin
      s_next.rvalid = 1'b1;
      unique case (reg_addr_i)
        `CMT_ADDR_INPUT_CURRENT_LIMIT_UVLO: s_next.rdata = {2'b00, s_reg.input_current_limit_uvlo[5:0]};
        `CMT_ADDR_MONITOR:   s_next.rdata = {1'b0, s_reg.band, s_reg.step, 2'b00};
        `CMT_ADDR_DPM_TIMER: s_next.rdata = s_reg.dpm_timer;
        default:             s_next.rdata = `CMT_READ_UNMAPPED;
      endcase
    end

    // band search; a trigger while busy is dropped rather than restarting the sweep
    unique case (s_reg.mon_state)
      MON_IDLE: begin
        if (start) begin
          s_next.band_sel   = `CMT_BAND_TOP;
          s_next.settle_cnt = 16'h0000;
          s_next.mon_state  = MON_SETTLE;
        end
      end
      MON_SETTLE: begin
        if (s_reg.settle_cnt == SETTLE_LAST) begin
          s_next.mon_state = MON_EVAL;
        end else begin
          s_next.settle_cnt = s_reg.settle_cnt + 16'h0001;
        end
      end
      MON_EVAL: begin
        if (s_reg.step_filt != `CMT_STEP_NONE) begin
          s_next.band      = s_reg.band_sel;
          s_next.step      = s_reg.step_filt;
          s_next.done      = 1'b1;
          s_next.mon_state = MON_IDLE;
        end else if (s_reg.band_sel == `CMT_BAND_BOTTOM) begin
          s_next.band      = `CMT_BAND_BOTTOM;
          s_next.step      = `CMT_STEP_NONE;
          s_next.done      = 1'b1;
          s_next.mon_state = MON_IDLE;
        end else begin
          s_next.band_sel   = s_reg.band_sel - 2'h1;
          s_next.settle_cnt = 16'h0000;
          s_next.mon_state  = MON_SETTLE;
        end
      end
    endcase

    // configuration writes; reserved lockout codes are refused and the old code stays
    if (wr_input_current_limit) begin
      s_next.input_current_limit_uvlo[`CMT_INPUT_CURRENT_LIMIT_MSB:`CMT_INPUT_CURRENT_LIMIT_LSB] = reg_wdata_i[`CMT_INPUT_CURRENT_LIMIT_MSB:`CMT_INPUT_CURRENT_LIMIT_LSB];
      if (reg_wdata_i[`CMT_UVLO_MSB:`CMT_UVLO_LSB] > `CMT_UVLO_RSVD_MAX) begin
        s_next.input_current_limit_uvlo[`CMT_UVLO_MSB:`CMT_UVLO_LSB] = reg_wdata_i[`CMT_UVLO_MSB:`CMT_UVLO_LSB];
      end
    end
    if (wr_dpm) begin
      s_next.dpm_timer = reg_wdata_i;
    end

    // soft reset wins over everything in the same cycle, including a sweep in flight
    if (soft_reset) begin
      s_next.input_current_limit_uvlo = CORE_RESET.input_current_limit_uvlo;
      s_next.dpm_timer = CORE_RESET.dpm_timer;
      s_next.band      = CORE_RESET.band;
      s_next.step      = CORE_RESET.step;
      s_next.band_sel  = CORE_RESET.band_sel;
      s_next.mon_state = MON_IDLE;
      s_next.done      = 1'b0;
    end

    // decoded values are taken from the next fields, so they update on the same edge as them
    s_next.input_current_limit_ma = (s_next.input_current_limit_uvlo[5] ? `CMT_INPUT_CURRENT_LIMIT_W2_MA : 10'h000)
                   + (s_next.input_current_limit_uvlo[4] ? `CMT_INPUT_CURRENT_LIMIT_W1_MA : 10'h000)
                   + (s_next.input_current_limit_uvlo[3] ? `CMT_INPUT_CURRENT_LIMIT_W0_MA : 10'h000);
    s_next.floor_mv = `CMT_FLOOR_BASE_MV
                    + 13'(s_next.dpm_timer[`CMT_FLOOR_MSB:`CMT_FLOOR_LSB]) * `CMT_FLOOR_STEP_MV;
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= CORE_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign reg_rdata_o                    = s_reg.rdata;
  assign reg_rvalid_o                   = s_reg.rvalid;
  assign monitor_band_select_o          = s_reg.band_sel;
  assign monitor_busy_o                 = s_reg.mon_state != MON_IDLE;
  assign monitor_done_o                 = s_reg.done;
  assign monitor_coarse_band_o          = s_reg.band;
  assign monitor_fine_step_o            = s_reg.step;
  assign input_current_limit_o          = s_reg.input_current_limit_uvlo[`CMT_INPUT_CURRENT_LIMIT_MSB:`CMT_INPUT_CURRENT_LIMIT_LSB];
  assign input_current_limit_ma_o       = s_reg.input_current_limit_ma;
  assign battery_undervoltage_lockout_o = s_reg.input_current_limit_uvlo[`CMT_UVLO_MSB:`CMT_UVLO_LSB];
  assign input_dpm_disable_o            = s_reg.dpm_timer[`CMT_BIT_DPM_DISABLE];
  assign input_voltage_floor_o          = s_reg.dpm_timer[`CMT_FLOOR_MSB:`CMT_FLOOR_LSB];
  assign input_voltage_floor_mv_o       = s_reg.floor_mv;
  assign timer_half_speed_enable_o      = s_reg.dpm_timer[`CMT_BIT_HALF_SPEED];
  assign safety_timer_select_o          = s_reg.dpm_timer[`CMT_TMR_MSB:`CMT_TMR_LSB];

  // ------------------------------------------------------------
  // safety timer
  // ------------------------------------------------------------
  cmt_safety_timer #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_timer (
    .core_clk_i                (core_clk_i),
    .rst_n_i                   (rst_n),
    .charging_active_i         (charging_active_i),
    .constant_current_phase_i  (constant_current_phase_i),
    .constant_voltage_phase_i  (constant_voltage_phase_i),
    .timer_half_speed_enable_i (timer_half_speed_enable_o),
    .safety_timer_select_i     (safety_timer_select_o),
    .safety_timer_expired_o    (safety_timer_expired_o)
  );

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n);

  sequence seq_sweep_start;
    !monitor_busy_o && start && !soft_reset;
  endsequence
  sequence seq_top_band;
    monitor_busy_o && monitor_band_select_o == `CMT_BAND_TOP;
  endsequence
  sequence seq_empty_band;
    s_reg.mon_state == MON_EVAL && s_reg.step_filt == `CMT_STEP_NONE && !soft_reset;
  endsequence

  chk_soft_reset_all: assert property (
    soft_reset |=> input_current_limit_o == 3'h0 && battery_undervoltage_lockout_o == 3'h2
                   && safety_timer_select_o == 2'h1 && input_voltage_floor_mv_o == 13'h11F8)
    else $error("soft reset did not restore defaults");
  chk_soft_bit_zero: assert property (
    reg_rd_i && reg_addr_i == `CMT_ADDR_INPUT_CURRENT_LIMIT_UVLO |=> reg_rvalid_o && !reg_rdata_o[7])
    else $error("soft reset bit read back as one");
  chk_input_current_limit_weights: assert property (
    wr_input_current_limit && !soft_reset && reg_wdata_i[5:3] == 3'h5 |=> input_current_limit_ma_o == 10'h0FA)
    else $error("input limit weights wrong");
  chk_uvlo_reserved: assert property (
    wr_input_current_limit && !soft_reset && reg_wdata_i[2:0] <= 3'h1
    |=> battery_undervoltage_lockout_o == $past(battery_undervoltage_lockout_o))
    else $error("reserved lockout code accepted");
  chk_monitor_reads: assert property (
    reg_rd_i && reg_addr_i == `CMT_ADDR_MONITOR
    |=> reg_rdata_o[7] == 1'b0 && reg_rdata_o[1:0] == 2'b00 && reg_rdata_o[6:5] == $past(monitor_coarse_band_o))
    else $error("monitor register read pattern wrong");
  chk_sweep_from_top: assert property (
    seq_sweep_start |=> seq_top_band)
    else $error("sweep did not begin at the top band");
  chk_band_step_down: assert property (
    seq_empty_band ##0 monitor_band_select_o != `CMT_BAND_BOTTOM
    |=> monitor_band_select_o == $past(monitor_band_select_o) - 2'h1 && s_reg.mon_state == MON_SETTLE)
    else $error("empty band did not move one band down");
  chk_result_band: assert property (
    monitor_done_o && monitor_fine_step_o != `CMT_STEP_NONE
    |-> monitor_coarse_band_o == $past(monitor_band_select_o) && monitor_fine_step_o == $past(s_reg.step_filt))
    else $error("reported band or step differs from the band searched");
  chk_empty_result: assert property (
    seq_empty_band ##0 monitor_band_select_o == `CMT_BAND_BOTTOM
    |=> monitor_done_o && monitor_coarse_band_o == 2'h0 && monitor_fine_step_o == 3'h0)
    else $error("failed sweep did not report zero");
  chk_floor_write: assert property (
    wr_dpm && !soft_reset
    |=> input_dpm_disable_o == $past(reg_wdata_i[7])
        && input_voltage_floor_mv_o == 13'h1068 + 13'($past(reg_wdata_i[6:4])) * 13'h0064)
    else $error("input floor write not applied");
endmodule

// *** testbench/cmt_battery_model.sv ***
// behavioural battery comparator: fine step of whichever band the monitor selects
`timescale 1ns/10ps
module cmt_battery_model (
  input  wire cmt_pkg::cmt_band_type band_select_i,
  input  wire logic [6:0]            level_pct_i,
  output cmt_pkg::cmt_step_type      step_o
);
  import cmt_pkg::*;
  int over;
  // ------------------------------------------------------------
  // comparator
  // ------------------------------------------------------------
  // percent above the band base; a cell below its band reads no step, so the sweep must step down
  always_comb begin
    over = int'(level_pct_i) - 60 - 10 * int'(band_select_i);
    if (over > 8) step_o = 3'h7;
    else if (over > 6) step_o = 3'h6;
    else if (over > 4) step_o = 3'h3;
    else if (over > 2) step_o = 3'h2;
    else if (over > 0) step_o = 3'h1;
    else step_o = 3'h0;
  end
endmodule

// *** testbench/cmt_charger_monitor_timer_regs_test.sv ***
// self-checking bench: register access, battery monitor sweep and safety timer
`timescale 1ns/10ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin num_errors++; $display("BAD %s exp %0h got %0h", nm, e, g); end end
module cmt_charger_monitor_timer_regs_test;
  import cmt_pkg::*;
  localparam int SETTLE = 8;
  int           num_errors = 0;
  int           num_checks = 0;
  logic         clk = 1'b0;
  logic         rst_n = 1'b0;
  logic         wr = 1'b0;
  logic         rd = 1'b0;
  logic         lpr = 1'b0;
  logic         chg = 1'b0;
  logic         cc = 1'b0;
  logic         cv = 1'b0;
  logic         busy, half;
  logic [2:0]   lim, uvlo, flr;
  logic [1:0]   tsel;
  logic [7:0]   addr = 8'h00;
  logic [7:0]   wdata = 8'h00;
  logic [6:0]   pct = 7'h00;
  logic [7:0]   rdata;
  logic         rvalid, done, dis, expd;
  logic [9:0]   ma;
  logic [12:0]  mv;
  cmt_band_type bsel, band;
  cmt_step_type step_in, step;

  // short tick and settle counts keep the timer runs inside the cycle budget
  cmt_charger_monitor_timer_regs #(.TICK_CYCLES(2), .SETTLE_CYCLES(SETTLE)) u_dut (
    .core_clk_i(clk), .rst_n_i(rst_n), .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .monitor_step_i(step_in), .low_power_request_i(lpr),
    .monitor_band_select_o(bsel), .monitor_busy_o(busy), .monitor_done_o(done), .monitor_coarse_band_o(band),
    .monitor_fine_step_o(step), .charging_active_i(chg), .constant_current_phase_i(cc),
    .constant_voltage_phase_i(cv), .safety_timer_expired_o(expd), .input_current_limit_o(lim),
    .input_current_limit_ma_o(ma), .battery_undervoltage_lockout_o(uvlo), .input_dpm_disable_o(dis),
    .input_voltage_floor_o(flr), .input_voltage_floor_mv_o(mv), .timer_half_speed_enable_o(half),
    .safety_timer_select_o(tsel));
  cmt_battery_model u_batt (.band_select_i(bsel), .level_pct_i(pct), .step_o(step_in));

  // ------------------------------------------------------------
  // access tasks
  // ------------------------------------------------------------
  // each starts one edge later so a strobe is never lowered and raised in one time step
  initial forever #2 clk = ~clk;
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 addr = a;
    wdata = d;
    wr = 1'b1;
    @(posedge clk);
    #1 wr = 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    #1 addr = a;
    rd = 1'b1;
    @(posedge clk);
    #1 rd = 1'b0;
    `CHK("rvalid", 1'b1, rvalid)
    `CHK("rdata", e, rdata)
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // start a sweep by register or by low-power request, then time it and check the result
  task automatic sweep(input logic [6:0] p, input cmt_band_type b, input cmt_step_type s, input logic via_pin);
    int i;
    int n;
    n = (s === 3'h0) ? 4 : 4 - int'(b);
    i = 0;
    pct = p;
    if (via_pin) begin
      @(posedge clk);
      #1 lpr = 1'b1;
      @(posedge clk);
      #1 lpr = 1'b0;
    end else wr_reg(8'h0A, 8'h80);
    `CHK("busy", 1'b1, busy)
    while (done !== 1'b1 && i < 60) begin
      @(posedge clk);
      #1 i++;
    end
    if (i == 60) begin
      num_errors++;
      tally_and_finish();
    end
    `CHK("latency", (SETTLE + 1) * n, i)
    `CHK("busy_end", 1'b0, busy)
    `CHK("band", b, band)
    `CHK("step", s, step)
    rd_reg(8'h0A, {1'b0, b, s, 2'b00});
  endtask
  task automatic hold_chk(input int n, input logic e);
    repeat (n) @(posedge clk);
    #1 `CHK("expired", e, expd)
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (3) @(posedge clk);
    rd_reg(8'h09, 8'h02);
    rd_reg(8'h0B, 8'h4A);
    `CHK("floor_mv", 13'h11F8, mv)
    `CHK("limit_ma", 10'h000, ma)
    $display("test defaults done");
    for (int c = 0; c < 8; c++) begin
      wr_reg(8'h09, {2'b00, c[2:0], 3'b010});
      rd_reg(8'h09, {2'b00, c[2:0], 3'b010});
      `CHK("limit_ma", 10'((c[2] ? 10'h0C8 : 10'h000) + (c[1] ? 10'h064 : 10'h000) + (c[0] ? 10'h032 : 10'h000)), ma)
      `CHK("limit_code", c[2:0], lim)
    end
    wr_reg(8'h09, 8'h4B);
    rd_reg(8'h09, 8'h0B);
    wr_reg(8'h09, 8'h08);
    rd_reg(8'h09, 8'h0B);
    wr_reg(8'h09, 8'h09);
    rd_reg(8'h09, 8'h0B);
    wr_reg(8'h09, 8'h0A);
    rd_reg(8'h09, 8'h0A);
    `CHK("lockout", 3'h2, uvlo)
    $display("test limit and lockout done");
    for (int c = 0; c < 8; c++) begin
      wr_reg(8'h0B, {1'b1, c[2:0], 4'h5});
      rd_reg(8'h0B, {1'b1, c[2:0], 4'h5});
      `CHK("floor_mv", 13'(13'h1068 + c * 13'h0064), mv)
      `CHK("dpm_off", 1'b1, dis)
      `CHK("floor_code", c[2:0], flr)
    end
    $display("test input floor done");
    sweep(7'd95, 2'h3, 3'h3, 1'b0);
    sweep(7'd83, 2'h2, 3'h2, 1'b1);
    sweep(7'd79, 2'h1, 3'h7, 1'b0);
    sweep(7'd67, 2'h0, 3'h6, 1'b0);
    sweep(7'd61, 2'h0, 3'h1, 1'b0);
    sweep(7'd55, 2'h0, 3'h0, 1'b0);
    sweep(7'd75, 2'h1, 3'h3, 1'b0);
    wr_reg(8'h09, 8'h80);
    rd_reg(8'h09, 8'h02);
    rd_reg(8'h0B, 8'h4A);
    rd_reg(8'h0A, 8'h00);
    `CHK("limit_ma", 10'h000, ma)
    `CHK("floor_mv", 13'h11F8, mv)
    $display("test monitor and soft reset done");
    wr_reg(8'h0B, 8'h40);
    chg = 1'b1;
    `CHK("timer_sel", 2'h0, tsel)
    hold_chk(3550, 1'b0);
    hold_chk(100, 1'b1);
    chg = 1'b0;
    wr_reg(8'h0B, 8'h48);
    chg = 1'b1;
    `CHK("half_en", 1'b1, half)
    hold_chk(7150, 1'b0);
    hold_chk(100, 1'b1);
    wr_reg(8'h0B, 8'h4E);
    `CHK("timer_sel", 2'h3, tsel)
    hold_chk(4, 1'b0);
    // constant current, then constant voltage: the half-speed bit must not slow the timer there
    cc = 1'b1;
    wr_reg(8'h0B, 8'h48);
    hold_chk(3550, 1'b0);
    hold_chk(100, 1'b1);
    cc = 1'b0;
    cv = 1'b1;
    chg = 1'b0;
    wr_reg(8'h0B, 8'h48);
    chg = 1'b1;
    hold_chk(3550, 1'b0);
    hold_chk(100, 1'b1);
    cv = 1'b0;
    chg = 1'b0;
    wr_reg(8'h0B, 8'h42);
    chg = 1'b1;
    `CHK("timer_sel", 2'h1, tsel)
    hold_chk(21550, 1'b0);
    hold_chk(100, 1'b1);
    $display("test safety timer done");
    tally_and_finish();
  end
endmodule
